// ==== logic/balu_pkg.sv ====
// Package: operation codes, flag layout and carriers for the byte ALU
package balu_pkg;
    localparam int DATA_W = 8;
    localparam int WORD_W = 16;
    localparam int CYC_BYTE = 1;
    localparam int CYC_WORD = 2;
    localparam logic [7:0] ALL_ONES = 8'hff;
    localparam logic [7:0] ALL_ZERO = 8'h00;
    // Flag positions inside the flag vector
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;
    localparam int FLG_V = 3;
    localparam int FLG_S = 4;
    localparam int FLG_H = 5;
    localparam logic [5:0] FLAGS_RST = 6'h00;

    typedef enum logic [4:0] {
        OP_SUM_REGS, OP_SUM_CARRY_REGS, OP_SUM_IMM_WORD,
        OP_DIFF_REGS, OP_DIFF_IMM, OP_DIFF_BORROW_REGS, OP_DIFF_BORROW_IMM,
        OP_DIFF_IMM_WORD, OP_CONJ_REGS, OP_CONJ_IMM, OP_DISJ_REGS, OP_DISJ_IMM,
        OP_XOR_REGS, OP_INVERT_BITS, OP_ZERO_MINUS, OP_SET_BITS, OP_CLEAR_BITS,
        OP_PLUS_ONE, OP_MINUS_ONE, OP_ZERO_SIGN_TEST, OP_ZERO_REG, OP_ALL_ONES
    } balu_op_t;

    typedef struct packed {
        balu_op_t op;
        logic [7:0] dst;
        logic [7:0] srcReg;
        logic [7:0] imm;
        logic [7:0] dstHigh;
    } balu_req_t;

    typedef struct packed {
        logic [15:0] result;
        logic wide;
        logic writeEn;
    } balu_rsp_t;
endpackage : balu_pkg

// ==== logic/balu_alu.sv ====
// Byte ALU datapath with status flags and two-cycle word operations
`timescale 1ns/100ps
// Functional notes
// - Register sums write dst+src(+C), update Z C N V H, one cycle
// - Word immediate sum adds to register pair, updates Z C N V S, two cycles
// - Register differences write dst-src(-C), update Z C N V H, one cycle
// - Immediate subtract and negate write dst, update Z C N V H, one cycle
// - Immediate subtract with borrow writes dst-imm-C, updates Z C N V H
// - Word immediate subtract on register pair, updates Z C N V S, two cycles
// - AND with register or immediate updates only Z N V, one cycle
// - OR, XOR and self-XOR clear update only Z N V, one cycle
// - Set bits ORs mask with Z N V; all-ones load touches no flag
// - Clear bits ANDs inverted mask; complement updates Z C N V
// - Plus one, minus one and test update only Z N V, one cycle
module balu_alu (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic reqValid,
    input wire balu_pkg::balu_req_t req,
    output logic busy,
    output logic doneValid,
    output balu_pkg::balu_rsp_t rsp,
    output logic [5:0] flags
);
    typedef struct packed {
        logic busy;
        logic done;
        balu_pkg::balu_rsp_t rsp;
        logic [5:0] flags;
        logic [15:0] wordRes;
        logic [5:0] wordFlags;
    } balu_state_t;

    balu_state_t st_r;
    balu_state_t st_nxt;

    // --------------------------------------------------------------
    // Operation decode
    // --------------------------------------------------------------
    logic [7:0] a, b, res;
    logic cin, isSub, isArith, carryOut, halfOut, ovf;
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [16:0] w17;
    logic [5:0] f;
    logic [15:0] pair;

    always_comb begin
        st_nxt = st_r;
        a = req.dst;
        b = req.srcReg;
        cin = 1'h0;
        isSub = 1'h0;
        isArith = 1'h0;
        res = 8'h00;
        f = st_r.flags;
        pair = {req.dstHigh, req.dst};
        w17 = 17'h00000;
        unique case (req.op)
            balu_pkg::OP_SUM_CARRY_REGS: cin = st_r.flags[balu_pkg::FLG_C];
            balu_pkg::OP_DIFF_IMM: b = req.imm;
            balu_pkg::OP_DIFF_BORROW_REGS: cin = st_r.flags[balu_pkg::FLG_C];
            balu_pkg::OP_DIFF_BORROW_IMM: begin
                b = req.imm;
                cin = st_r.flags[balu_pkg::FLG_C];
            end
            balu_pkg::OP_ZERO_MINUS: begin
                a = balu_pkg::ALL_ZERO;
                b = req.dst;
            end
            default: ;
        endcase
        isSub = req.op inside {balu_pkg::OP_DIFF_REGS, balu_pkg::OP_DIFF_IMM,
            balu_pkg::OP_DIFF_BORROW_REGS, balu_pkg::OP_DIFF_BORROW_IMM,
            balu_pkg::OP_ZERO_MINUS};
        isArith = isSub || req.op inside {balu_pkg::OP_SUM_REGS, balu_pkg::OP_SUM_CARRY_REGS};
        // Borrow is carry out of the low nibble and byte of a - b - cin
        sum9 = isSub ? ({1'h0, a} - {1'h0, b} - {8'h00, cin})
                     : ({1'h0, a} + {1'h0, b} + {8'h00, cin});
        sum5 = isSub ? ({1'h0, a[3:0]} - {1'h0, b[3:0]} - {4'h0, cin})
                     : ({1'h0, a[3:0]} + {1'h0, b[3:0]} + {4'h0, cin});
        carryOut = sum9[8];
        halfOut = sum5[4];
        ovf = isSub ? ((a[7] ^ b[7]) & (a[7] ^ sum9[7]))
                    : (~(a[7] ^ b[7]) & (a[7] ^ sum9[7]));
        unique case (req.op)
            balu_pkg::OP_CONJ_REGS: res = req.dst & req.srcReg;
            balu_pkg::OP_CONJ_IMM: res = req.dst & req.imm;
            balu_pkg::OP_DISJ_REGS: res = req.dst | req.srcReg;
            balu_pkg::OP_DISJ_IMM: res = req.dst | req.imm;
            balu_pkg::OP_XOR_REGS: res = req.dst ^ req.srcReg;
            balu_pkg::OP_ZERO_REG: res = req.dst ^ req.dst;
            balu_pkg::OP_SET_BITS: res = req.dst | req.imm;
            balu_pkg::OP_ALL_ONES: res = balu_pkg::ALL_ONES;
            balu_pkg::OP_CLEAR_BITS: res = req.dst & (balu_pkg::ALL_ONES - req.imm);
            balu_pkg::OP_INVERT_BITS: res = balu_pkg::ALL_ONES - req.dst;
            balu_pkg::OP_PLUS_ONE: res = req.dst + 8'h01;
            balu_pkg::OP_MINUS_ONE: res = req.dst - 8'h01;
            balu_pkg::OP_ZERO_SIGN_TEST: res = req.dst & req.dst;
            default: res = sum9[7:0];
        endcase

        // ----------------------------------------------------------
        // Flag update, untouched flags kept
        // ----------------------------------------------------------
        if (isArith) begin
            f[balu_pkg::FLG_C] = carryOut;
            f[balu_pkg::FLG_H] = halfOut;
            f[balu_pkg::FLG_V] = ovf;
        end else if (req.op == balu_pkg::OP_PLUS_ONE) begin
            f[balu_pkg::FLG_V] = (req.dst == 8'h7f);
        end else if (req.op == balu_pkg::OP_MINUS_ONE) begin
            f[balu_pkg::FLG_V] = (req.dst == 8'h80);
        end else begin
            f[balu_pkg::FLG_V] = 1'h0;
        end
        if (req.op == balu_pkg::OP_INVERT_BITS) begin
            f[balu_pkg::FLG_C] = 1'h1;
        end
        f[balu_pkg::FLG_Z] = (res == 8'h00);
        f[balu_pkg::FLG_N] = res[7];
        if (req.op == balu_pkg::OP_ALL_ONES) begin
            f = st_r.flags;
        end

        // Word ops: pair computed now, published on the second cycle
        if (req.op == balu_pkg::OP_SUM_IMM_WORD) begin
            w17 = {1'h0, pair} + {9'h000, req.imm};
        end else begin
            w17 = {1'h0, pair} - {9'h000, req.imm};
        end

        st_nxt.done = 1'h0;
        if (st_r.busy) begin
            st_nxt.busy = 1'h0;
            st_nxt.done = 1'h1;
            st_nxt.rsp.result = st_r.wordRes;
            st_nxt.rsp.wide = 1'h1;
            st_nxt.rsp.writeEn = 1'h1;
            st_nxt.flags = st_r.wordFlags;
        end else if (reqValid) begin
            if (req.op inside {balu_pkg::OP_SUM_IMM_WORD, balu_pkg::OP_DIFF_IMM_WORD}) begin
                st_nxt.busy = 1'h1;
                st_nxt.wordRes = w17[15:0];
                st_nxt.wordFlags = st_r.flags;
                st_nxt.wordFlags[balu_pkg::FLG_C] = w17[16];
                st_nxt.wordFlags[balu_pkg::FLG_Z] = (w17[15:0] == 16'h0000);
                st_nxt.wordFlags[balu_pkg::FLG_N] = w17[15];
                st_nxt.wordFlags[balu_pkg::FLG_V] = (req.op == balu_pkg::OP_SUM_IMM_WORD)
                    ? (~pair[15] & w17[15]) : (pair[15] & ~w17[15]);
                st_nxt.wordFlags[balu_pkg::FLG_S] = w17[15] ^
                    ((req.op == balu_pkg::OP_SUM_IMM_WORD)
                    ? (~pair[15] & w17[15]) : (pair[15] & ~w17[15]));
            end else begin
                st_nxt.done = 1'h1;
                st_nxt.rsp.result = {8'h00, res};
                st_nxt.rsp.wide = 1'h0;
                st_nxt.rsp.writeEn = 1'h1;
                st_nxt.flags = f;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r <= '0;
            st_r.flags <= balu_pkg::FLAGS_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign busy = st_r.busy;
    assign doneValid = st_r.done;
    assign rsp = st_r.rsp;
    assign flags = st_r.flags;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic isWordReq;
    assign isWordReq = reqValid && !busy &&
        (req.op inside {balu_pkg::OP_SUM_IMM_WORD, balu_pkg::OP_DIFF_IMM_WORD});

    byte_one_cycle_a: assert property (reqValid && !busy && !isWordReq |=> doneValid)
        else $error("byte op did not finish in one cycle");
    word_two_cycle_a: assert property (isWordReq |=> !doneValid ##1 doneValid && rsp.wide)
        else $error("word op did not finish in two cycles");
    sum_value_a: assert property (reqValid && !busy && req.op == balu_pkg::OP_SUM_REGS
        |=> rsp.result[7:0] == $past(req.dst) + $past(req.srcReg))
        else $error("register sum wrong");
    word_diff_a: assert property (reqValid && !busy && req.op == balu_pkg::OP_DIFF_IMM_WORD
        |=> ##1 rsp.result == $past({req.dstHigh, req.dst}, 2) - {8'h00, $past(req.imm, 2)})
        else $error("word difference wrong");
    negate_value_a: assert property (reqValid && !busy && req.op == balu_pkg::OP_ZERO_MINUS
        |=> rsp.result[7:0] == 8'h00 - $past(req.dst))
        else $error("negate wrong");
    logic_carry_a: assert property (reqValid && !busy && req.op inside {
        balu_pkg::OP_CONJ_IMM, balu_pkg::OP_XOR_REGS, balu_pkg::OP_PLUS_ONE}
        |=> flags[balu_pkg::FLG_C] == $past(flags[balu_pkg::FLG_C])
            && flags[balu_pkg::FLG_H] == $past(flags[balu_pkg::FLG_H]))
        else $error("logic op touched carry or half carry");
    ones_keep_a: assert property (reqValid && !busy && req.op == balu_pkg::OP_ALL_ONES
        |=> $stable(flags) && rsp.result[7:0] == 8'hff)
        else $error("all-ones load changed flags");
    invert_carry_a: assert property (reqValid && !busy
        && req.op == balu_pkg::OP_INVERT_BITS |=> flags[balu_pkg::FLG_C])
        else $error("complement did not set carry");
    zero_flag_a: assert property (doneValid && !rsp.wide
        && $past(req.op) != balu_pkg::OP_ALL_ONES
        |-> flags[balu_pkg::FLG_Z] == (rsp.result[7:0] == 8'h00))
        else $error("zero flag mismatch");

    word_cov_c: cover property (isWordReq ##2 doneValid);
    borrow_cov_c: cover property (reqValid && req.op == balu_pkg::OP_DIFF_BORROW_IMM ##1 doneValid);
    clear_cov_c: cover property (reqValid && req.op == balu_pkg::OP_ZERO_REG ##1 flags[1]);
    refuse_cov_c: cover property (busy && reqValid ##1 doneValid ##1 !busy);
endmodule : balu_alu

// ==== verif/balu_host.sv ====
// Partner model: decoder and register file that issue requests and take write-backs
`timescale 1ns/100ps
module balu_host (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic issue,
    input wire balu_pkg::balu_req_t cmd,
    output logic reqValid,
    output balu_pkg::balu_req_t req,
    input wire logic doneValid,
    input wire balu_pkg::balu_rsp_t rsp,
    output logic [15:0] lastWrite
);
    // Idle operands toggle, so late sampling shows up as garbage
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reqValid <= 1'h0;
            req <= '0;
            lastWrite <= 16'h0000;
        end else begin
            reqValid <= issue;
            req <= issue ? cmd : ~req;
            if (doneValid && rsp.writeEn) begin
                lastWrite <= rsp.result;
            end
        end
    end
endmodule : balu_host

// ==== verif/tb_top.sv ====
// Testbench for the byte ALU: scenario tasks, partner host and verdict
`timescale 1ns/100ps
module tb_top;
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic issue = 1'h0;
    balu_pkg::balu_req_t cmd = '0;
    logic reqValid;
    balu_pkg::balu_req_t req;
    logic busy;
    logic doneValid;
    balu_pkg::balu_rsp_t rsp;
    logic [5:0] flags;
    logic [15:0] lastWrite;
    int err_total = 0;
    int checks_done = 0;
    always #20 clk_sys = ~clk_sys;
    balu_alu uut (.clk_sys(clk_sys), .rst(rst), .reqValid(reqValid), .req(req), .busy(busy),
        .doneValid(doneValid), .rsp(rsp), .flags(flags));
    balu_host host (.clk_sys(clk_sys), .rst(rst), .issue(issue), .cmd(cmd),
        .reqValid(reqValid), .req(req), .doneValid(doneValid), .rsp(rsp), .lastWrite(lastWrite));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Poke keeps the request up into the busy cycle, where it must be ignored
    task automatic run(input balu_pkg::balu_op_t op, input logic [7:0] d, input logic [7:0] s,
        input logic [7:0] k, input logic [15:0] er, input logic [5:0] ef,
        input logic poke = 1'h0);
        logic w;
        w = (op == balu_pkg::OP_SUM_IMM_WORD) || (op == balu_pkg::OP_DIFF_IMM_WORD);
        @(posedge clk_sys);
        issue <= 1'h1;
        cmd <= '{op: op, dst: d, srcReg: s, imm: k, dstHigh: d};
        @(posedge clk_sys);
        issue <= poke;
        @(posedge clk_sys);
        issue <= 1'h0;
        #1;
        if (w) begin
            chk("busy", 16'h0001, {15'h0, busy});
            chk("early done", 16'h0000, {15'h0, doneValid});
            @(posedge clk_sys);
            #1;
        end
        chk("done", 16'h0001, {15'h0, doneValid});
        chk("result", er, rsp.result);
        chk("wide", {15'h0, w}, {15'h0, rsp.wide});
        chk("write enable", 16'h0001, {15'h0, rsp.writeEn});
        chk("flags", {10'h0, ef}, {10'h0, flags});
        @(posedge clk_sys);
        #1;
        chk("done after pulse", 16'h0000, {15'h0, doneValid});
        chk("busy after", 16'h0000, {15'h0, busy});
        chk("written back", er, lastWrite);
    endtask : run
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_sums();
        run(balu_pkg::OP_SUM_REGS, 8'h0f, 8'h01, 8'h00, 16'h0010, 6'h20);
        run(balu_pkg::OP_SUM_REGS, 8'hff, 8'h01, 8'h00, 16'h0000, 6'h23);
        run(balu_pkg::OP_SUM_CARRY_REGS, 8'h7f, 8'h00, 8'h00, 16'h0080, 6'h2c);
        $display("test_sums finished");
    endtask : test_sums
    task automatic test_unary();
        run(balu_pkg::OP_INVERT_BITS, 8'h0f, 8'h00, 8'h00, 16'h00f0, 6'h25);
        run(balu_pkg::OP_PLUS_ONE, 8'h7f, 8'h00, 8'h00, 16'h0080, 6'h2d);
        run(balu_pkg::OP_MINUS_ONE, 8'h80, 8'h00, 8'h00, 16'h007f, 6'h29);
        run(balu_pkg::OP_ZERO_SIGN_TEST, 8'h00, 8'h00, 8'h00, 16'h0000, 6'h23);
        $display("test_unary finished");
    endtask : test_unary
    task automatic test_diffs();
        run(balu_pkg::OP_DIFF_REGS, 8'h10, 8'h01, 8'h00, 16'h000f, 6'h20);
        run(balu_pkg::OP_DIFF_BORROW_REGS, 8'h00, 8'h01, 8'h00, 16'h00ff, 6'h25);
        run(balu_pkg::OP_DIFF_BORROW_IMM, 8'h05, 8'h00, 8'h05, 16'h00ff, 6'h25);
        run(balu_pkg::OP_DIFF_IMM, 8'h80, 8'h00, 8'h01, 16'h007f, 6'h28);
        run(balu_pkg::OP_ZERO_MINUS, 8'h01, 8'h00, 8'h00, 16'h00ff, 6'h25);
        $display("test_diffs finished");
    endtask : test_diffs
    task automatic test_words();
        run(balu_pkg::OP_SUM_IMM_WORD, 8'hff, 8'h00, 8'h01, 16'h0000, 6'h23, 1'h1);
        run(balu_pkg::OP_DIFF_IMM_WORD, 8'h00, 8'h00, 8'h01, 16'hffff, 6'h35);
        $display("test_words finished");
    endtask : test_words
    task automatic test_logic();
        run(balu_pkg::OP_CONJ_REGS, 8'hf0, 8'h0f, 8'h00, 16'h0000, 6'h33);
        run(balu_pkg::OP_CONJ_IMM, 8'hff, 8'h00, 8'h81, 16'h0081, 6'h35);
        run(balu_pkg::OP_DISJ_REGS, 8'h00, 8'h00, 8'hff, 16'h0000, 6'h33);
        run(balu_pkg::OP_DISJ_IMM, 8'h80, 8'hff, 8'h01, 16'h0081, 6'h35);
        run(balu_pkg::OP_XOR_REGS, 8'haa, 8'h55, 8'h00, 16'h00ff, 6'h35);
        run(balu_pkg::OP_ZERO_REG, 8'h5a, 8'h5a, 8'h00, 16'h0000, 6'h33);
        run(balu_pkg::OP_ALL_ONES, 8'h00, 8'h00, 8'h00, 16'h00ff, 6'h33);
        run(balu_pkg::OP_SET_BITS, 8'h01, 8'h00, 8'h80, 16'h0081, 6'h35);
        run(balu_pkg::OP_CLEAR_BITS, 8'hff, 8'h00, 8'h0f, 16'h00f0, 6'h35);
        $display("test_logic finished");
    endtask : test_logic
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'h0;
        #1;
        chk("reset flags", 16'h0000, {10'h0, flags});
        test_sums();
        test_unary();
        test_diffs();
        test_words();
        test_logic();
        give_verdict();
    end
    // About 100 cycles of tests; the limit leaves ample margin
    initial begin
        #100000;
        err_total++;
        give_verdict();
    end
endmodule : tb_top
